// ### shared/crt_timing_pkg.sv
package crt_timing_pkg;

	// ----------------------------------------------------------------
	// Register indices (data port, selected by the index register)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_HTOTAL       = 6'h00;
	localparam logic [5:0] IDX_HDISP_END    = 6'h01;
	localparam logic [5:0] IDX_HBLANK_START = 6'h02;
	localparam logic [5:0] IDX_HBLANK_END   = 6'h03;
	localparam logic [5:0] IDX_HRET_START   = 6'h04;
	localparam logic [5:0] IDX_HRET_END     = 6'h05;
	localparam logic [5:0] IDX_VTOTAL_LOW   = 6'h06;
	localparam logic [5:0] IDX_OVERFLOW     = 6'h07;
	localparam logic [5:0] IDX_PRESET_ROW   = 6'h08;
	localparam logic [5:0] IDX_VRET_START   = 6'h10;
	localparam logic [5:0] IDX_VRET_END     = 6'h11;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int HBE_COMPAT_BIT   = 7;
	localparam int HBE_SKEW_HI      = 6;
	localparam int HBE_SKEW_LO      = 5;
	localparam int HBE_LOW_HI       = 4;
	localparam int HRE_HBE5_BIT     = 7;
	localparam int HRE_DELAY_HI     = 6;
	localparam int HRE_DELAY_LO     = 5;
	localparam int HRE_END_HI       = 4;
	localparam int OVF_VTOTAL8      = 0;
	localparam int OVF_VDE8         = 1;
	localparam int OVF_VRS8         = 2;
	localparam int OVF_VBS8         = 3;
	localparam int OVF_LCMP8        = 4;
	localparam int OVF_VTOTAL9      = 5;
	localparam int OVF_VDE9         = 6;
	localparam int OVF_VRS9         = 7;
	localparam int PRS_PAN_HI       = 6;
	localparam int PRS_PAN_LO       = 5;
	localparam int PRS_ROW_HI       = 4;
	localparam int VRE_PROTECT_BIT  = 7;

	// ----------------------------------------------------------------
	// Reset values and timing constants
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] HTOTAL_OFFSET  = 8'h04;
	localparam logic [3:0] CHAR_DIV       = 4'h8;
	localparam logic [4:0] ROW_MAX        = 5'h1F;
	localparam logic [2:0] PAN_SHIFT      = 3'h3;
	localparam int         SKEW_DEPTH     = 3;

endpackage : crt_timing_pkg

// ### src/crt_raster_timing_regs.sv
`timescale 1ns/10ps
module crt_raster_timing_regs
	import crt_timing_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ioWr,
	input  wire logic        ioRd,
	input  wire logic        ioSelData,
	input  wire logic [7:0]  ioWdata,
	input  wire logic        extProtect,
	input  wire logic [15:0] lightPenAddr,
	input  wire logic        vRetraceDone,
	output logic      [7:0]  ioRdata_r,
	output logic      [7:0]  charCount_r,
	output logic             hDispEn_r,
	output logic             hBlank_r,
	output logic             hSync_r,
	output logic             lineEnd_r,
	output logic      [9:0]  vTotal_r,
	output logic      [1:0]  vRetraceStartHi_r,
	output logic      [1:0]  vDispEndHi_r,
	output logic             vBlankStart8_r,
	output logic             lineCompare8_r,
	output logic      [4:0]  rowScan_r,
	output logic      [1:0]  bytePan_r,
	output logic      [4:0]  panPixels_r
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [5:0] crtIndex_r,  crtIndex_nxt;
	logic [7:0] hTotal_r,    hTotal_nxt;
	logic [7:0] hDispEnd_r,  hDispEnd_nxt;
	logic [7:0] hblank_start_r,           hblank_start_nxt;
	logic [7:0] hblank_end_and_skew_r,    hblank_end_and_skew_nxt;
	logic [7:0] hretrace_start_r,         hretrace_start_nxt;
	logic [7:0] hretrace_end_and_delay_r, hretrace_end_and_delay_nxt;
	logic [7:0] vertical_total_low_r,     vertical_total_low_nxt;
	logic [7:0] vertical_overflow_r,      vertical_overflow_nxt;
	logic [7:0] preset_row_and_byte_pan_r, preset_row_and_byte_pan_nxt;
	logic [7:0] vretrace_start_r,         vretrace_start_nxt;
	logic [7:0] vretrace_end_r,           vretrace_end_nxt;
	logic [7:0] rdData_nxt;
	logic       timingProt;
	logic       dataWr;

	assign dataWr = ioWr & ioSelData;
	assign timingProt = extProtect | vretrace_end_r[VRE_PROTECT_BIT];

	always_comb begin
		crtIndex_nxt                = crtIndex_r;
		hTotal_nxt                  = hTotal_r;
		hDispEnd_nxt                = hDispEnd_r;
		hblank_start_nxt            = hblank_start_r;
		hblank_end_and_skew_nxt     = hblank_end_and_skew_r;
		hretrace_start_nxt          = hretrace_start_r;
		hretrace_end_and_delay_nxt  = hretrace_end_and_delay_r;
		vertical_total_low_nxt      = vertical_total_low_r;
		vertical_overflow_nxt       = vertical_overflow_r;
		preset_row_and_byte_pan_nxt = preset_row_and_byte_pan_r;
		vretrace_start_nxt          = vretrace_start_r;
		vretrace_end_nxt            = vretrace_end_r;
		if (ioWr && !ioSelData) begin
			crtIndex_nxt = ioWdata[5:0];
		end
		if (dataWr) begin
			if (crtIndex_r == IDX_HTOTAL && !timingProt) begin
				hTotal_nxt = ioWdata;
			end else if (crtIndex_r == IDX_HDISP_END && !timingProt) begin
				hDispEnd_nxt = ioWdata;
			end else if (crtIndex_r == IDX_HBLANK_START && !timingProt) begin
				hblank_start_nxt = ioWdata;
			end else if (crtIndex_r == IDX_HBLANK_END && !timingProt) begin
				hblank_end_and_skew_nxt = ioWdata;
			end else if (crtIndex_r == IDX_HRET_START && !timingProt) begin
				hretrace_start_nxt = ioWdata;
			end else if (crtIndex_r == IDX_HRET_END && !timingProt) begin
				hretrace_end_and_delay_nxt = ioWdata;
			end else if (crtIndex_r == IDX_VTOTAL_LOW && !timingProt) begin
				vertical_total_low_nxt = ioWdata;
			end else if (crtIndex_r == IDX_OVERFLOW) begin
				// line-compare bit only sees extension protect
				if (!extProtect) begin
					vertical_overflow_nxt[OVF_LCMP8] = ioWdata[OVF_LCMP8];
				end
				if (!timingProt) begin
					vertical_overflow_nxt[OVF_VRS9:OVF_VTOTAL9] = ioWdata[OVF_VRS9:OVF_VTOTAL9];
					vertical_overflow_nxt[OVF_VBS8:OVF_VTOTAL8] = ioWdata[OVF_VBS8:OVF_VTOTAL8];
				end
			end else if (crtIndex_r == IDX_PRESET_ROW && !extProtect) begin
				preset_row_and_byte_pan_nxt = {1'b0, ioWdata[PRS_PAN_HI:0]};
			end else if (crtIndex_r == IDX_VRET_START) begin
				vretrace_start_nxt = ioWdata;
			end else if (crtIndex_r == IDX_VRET_END) begin
				vretrace_end_nxt = ioWdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_comb begin
		rdData_nxt = ioRdata_r;
		if (ioRd && !ioSelData) begin
			rdData_nxt = {2'b00, crtIndex_r};
		end else if (ioRd) begin
			if (crtIndex_r == IDX_HTOTAL) begin
				rdData_nxt = hTotal_r;
			end else if (crtIndex_r == IDX_HDISP_END) begin
				rdData_nxt = hDispEnd_r;
			end else if (crtIndex_r == IDX_HBLANK_START) begin
				rdData_nxt = hblank_start_r;
			end else if (crtIndex_r == IDX_HBLANK_END) begin
				rdData_nxt = hblank_end_and_skew_r;
			end else if (crtIndex_r == IDX_HRET_START) begin
				rdData_nxt = hretrace_start_r;
			end else if (crtIndex_r == IDX_HRET_END) begin
				rdData_nxt = hretrace_end_and_delay_r;
			end else if (crtIndex_r == IDX_VTOTAL_LOW) begin
				rdData_nxt = vertical_total_low_r;
			end else if (crtIndex_r == IDX_OVERFLOW) begin
				rdData_nxt = vertical_overflow_r;
			end else if (crtIndex_r == IDX_PRESET_ROW) begin
				rdData_nxt = preset_row_and_byte_pan_r;
			end else if (crtIndex_r == IDX_VRET_START) begin
				rdData_nxt = hblank_end_and_skew_r[HBE_COMPAT_BIT] ? vretrace_start_r
				                                                   : lightPenAddr[15:8];
			end else if (crtIndex_r == IDX_VRET_END) begin
				rdData_nxt = hblank_end_and_skew_r[HBE_COMPAT_BIT] ? vretrace_end_r
				                                                   : lightPenAddr[7:0];
			end else begin
				rdData_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			crtIndex_r                <= 6'h00;
			hTotal_r                  <= REG_RESET;
			hDispEnd_r                <= REG_RESET;
			hblank_start_r            <= REG_RESET;
			hblank_end_and_skew_r     <= REG_RESET;
			hretrace_start_r          <= REG_RESET;
			hretrace_end_and_delay_r  <= REG_RESET;
			vertical_total_low_r      <= REG_RESET;
			vertical_overflow_r       <= REG_RESET;
			preset_row_and_byte_pan_r <= REG_RESET;
			vretrace_start_r          <= REG_RESET;
			vretrace_end_r            <= REG_RESET;
			ioRdata_r                 <= 8'h00;
		end else begin
			crtIndex_r                <= crtIndex_nxt;
			hTotal_r                  <= hTotal_nxt;
			hDispEnd_r                <= hDispEnd_nxt;
			hblank_start_r            <= hblank_start_nxt;
			hblank_end_and_skew_r     <= hblank_end_and_skew_nxt;
			hretrace_start_r          <= hretrace_start_nxt;
			hretrace_end_and_delay_r  <= hretrace_end_and_delay_nxt;
			vertical_total_low_r      <= vertical_total_low_nxt;
			vertical_overflow_r       <= vertical_overflow_nxt;
			preset_row_and_byte_pan_r <= preset_row_and_byte_pan_nxt;
			vretrace_start_r          <= vretrace_start_nxt;
			vretrace_end_r            <= vretrace_end_nxt;
			ioRdata_r                 <= rdData_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Character clock divider and horizontal counter
	// ----------------------------------------------------------------
	logic [3:0] divCount_r, divCount_nxt;
	logic       charEn_r,   charEn_nxt;
	logic [7:0] count_nxt;
	logic       lineEnd_nxt;
	logic [5:0] hBlankEnd;
	logic       dispRaw_r,  dispRaw_nxt;
	logic       blankRaw_r, blankRaw_nxt;
	logic       syncRaw_r,  syncRaw_nxt;

	// six-bit end assembled from two registers
	assign hBlankEnd = {hretrace_end_and_delay_r[HRE_HBE5_BIT],
	                    hblank_end_and_skew_r[HBE_LOW_HI:0]};

	always_comb begin
		charEn_nxt   = 1'b0;
		divCount_nxt = divCount_r + 4'h1;
		if (divCount_r == CHAR_DIV - 4'h1) begin
			divCount_nxt = 4'h0;
			charEn_nxt   = 1'b1;
		end
		count_nxt    = charCount_r;
		lineEnd_nxt  = 1'b0;
		dispRaw_nxt  = dispRaw_r;
		blankRaw_nxt = blankRaw_r;
		syncRaw_nxt  = syncRaw_r;
		if (charEn_r) begin
			if (charCount_r == hTotal_r + HTOTAL_OFFSET) begin
				count_nxt   = 8'h00;
				lineEnd_nxt = 1'b1;
				dispRaw_nxt = 1'b1;
			end else begin
				count_nxt = charCount_r + 8'h01;
			end
			if (charCount_r == hDispEnd_r) begin
				dispRaw_nxt = 1'b0;
			end
			// flags follow the count being entered and survive the wrap
			if (blankRaw_r && count_nxt[5:0] == hBlankEnd) begin
				blankRaw_nxt = 1'b0;
			end
			if (count_nxt == hblank_start_r) begin
				blankRaw_nxt = 1'b1;
			end
			if (syncRaw_r && count_nxt[4:0] == hretrace_end_and_delay_r[HRE_END_HI:0]) begin
				syncRaw_nxt = 1'b0;
			end
			if (count_nxt == hretrace_start_r) begin
				syncRaw_nxt = 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Skew pipelines and outputs
	// ----------------------------------------------------------------
	logic [SKEW_DEPTH-1:0] dispPipe_r, dispPipe_nxt;
	logic [SKEW_DEPTH-1:0] syncPipe_r, syncPipe_nxt;
	logic [SKEW_DEPTH:0]   dispTaps,   syncTaps;
	logic [1:0]            deSkew,     hrDelay;
	logic                  dispOut_nxt, syncOut_nxt;

	assign deSkew   = hblank_end_and_skew_r[HBE_SKEW_HI:HBE_SKEW_LO];
	assign hrDelay  = hretrace_end_and_delay_r[HRE_DELAY_HI:HRE_DELAY_LO];
	assign dispTaps = {dispPipe_r, dispRaw_r};
	assign syncTaps = {syncPipe_r, syncRaw_r};

	always_comb begin
		dispPipe_nxt = dispPipe_r;
		syncPipe_nxt = syncPipe_r;
		if (charEn_r) begin
			dispPipe_nxt = {dispPipe_r[SKEW_DEPTH-2:0], dispRaw_r};
			syncPipe_nxt = {syncPipe_r[SKEW_DEPTH-2:0], syncRaw_r};
		end
		dispOut_nxt = dispTaps[deSkew];
		syncOut_nxt = syncTaps[hrDelay];
	end

	// ----------------------------------------------------------------
	// Row scan and byte pan
	// ----------------------------------------------------------------
	logic [4:0] rowScan_nxt;
	logic [1:0] panField;

	assign panField = preset_row_and_byte_pan_r[PRS_PAN_HI:PRS_PAN_LO];

	always_comb begin
		rowScan_nxt = rowScan_r;
		if (vRetraceDone) begin
			rowScan_nxt = preset_row_and_byte_pan_r[PRS_ROW_HI:0];
		end else if (lineEnd_r) begin
			// Cell height lives elsewhere; free-run rolls over past 1Fh
			rowScan_nxt = (rowScan_r == ROW_MAX) ? 5'h00 : rowScan_r + 5'h01;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			divCount_r        <= 4'h0;
			charEn_r          <= 1'b0;
			charCount_r       <= 8'h00;
			lineEnd_r         <= 1'b0;
			dispRaw_r         <= 1'b0;
			blankRaw_r        <= 1'b0;
			syncRaw_r         <= 1'b0;
			dispPipe_r        <= '0;
			syncPipe_r        <= '0;
			hDispEn_r         <= 1'b0;
			hBlank_r          <= 1'b0;
			hSync_r           <= 1'b0;
			rowScan_r         <= 5'h00;
			bytePan_r         <= 2'b00;
			panPixels_r       <= 5'h00;
			vTotal_r          <= 10'h000;
			vRetraceStartHi_r <= 2'b00;
			vDispEndHi_r      <= 2'b00;
			vBlankStart8_r    <= 1'b0;
			lineCompare8_r    <= 1'b0;
		end else begin
			divCount_r  <= divCount_nxt;
			charEn_r    <= charEn_nxt;
			charCount_r <= count_nxt;
			lineEnd_r   <= lineEnd_nxt;
			dispRaw_r   <= dispRaw_nxt;
			blankRaw_r  <= blankRaw_nxt;
			syncRaw_r   <= syncRaw_nxt;
			dispPipe_r  <= dispPipe_nxt;
			syncPipe_r  <= syncPipe_nxt;
			hDispEn_r   <= dispOut_nxt;
			hBlank_r    <= blankRaw_nxt;
			hSync_r     <= syncOut_nxt;
			rowScan_r   <= rowScan_nxt;
			bytePan_r   <= panField;
			panPixels_r <= {panField, PAN_SHIFT'(0)};
			vTotal_r    <= {vertical_overflow_nxt[OVF_VTOTAL9],
			                vertical_overflow_nxt[OVF_VTOTAL8], vertical_total_low_nxt};
			vRetraceStartHi_r <= {vertical_overflow_nxt[OVF_VRS9], vertical_overflow_nxt[OVF_VRS8]};
			vDispEndHi_r      <= {vertical_overflow_nxt[OVF_VDE9], vertical_overflow_nxt[OVF_VDE8]};
			vBlankStart8_r    <= vertical_overflow_nxt[OVF_VBS8];
			lineCompare8_r    <= vertical_overflow_nxt[OVF_LCMP8];
		end
	end

endmodule : crt_raster_timing_regs

// ### verif/crt_raster_timing_regs_asserts.sv
`timescale 1ns/10ps
module crt_raster_timing_regs_asserts
	import crt_timing_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ioWr,
	input  wire logic        ioRd,
	input  wire logic        ioSelData,
	input  wire logic [7:0]  ioWdata,
	input  wire logic        extProtect,
	input  wire logic [15:0] lightPenAddr,
	input  wire logic        vRetraceDone,
	input  wire logic [7:0]  ioRdata_r,
	input  wire logic [7:0]  charCount_r,
	input  wire logic        hBlank_r,
	input  wire logic        hSync_r,
	input  wire logic [9:0]  vTotal_r,
	input  wire logic [1:0]  vRetraceStartHi_r,
	input  wire logic [1:0]  vDispEndHi_r,
	input  wire logic        vBlankStart8_r,
	input  wire logic        lineCompare8_r,
	input  wire logic [4:0]  rowScan_r,
	input  wire logic [1:0]  bytePan_r,
	input  wire logic [4:0]  panPixels_r
);
	// ----------------------------------------
	// Shadow of the register file from port traffic
	// ----------------------------------------
	logic [5:0]       idx_r, idxNxt;
	logic [17:0][7:0] sh_r, shNxt;
	logic [7:0]       expRd;
	logic             prot;

	always_comb begin
		idxNxt = idx_r;
		shNxt = sh_r;
		prot = extProtect | sh_r[17][7];
		if (ioWr && !ioSelData) begin
			idxNxt = ioWdata[5:0];
		end
		if (ioWr && ioSelData) begin
			if (idx_r < 6'h08 && !prot) begin
				shNxt[idx_r[4:0]] = ioWdata;
			end
			if (idx_r == 6'h07 && !extProtect) begin
				shNxt[7][4] = ioWdata[4];
			end
			if (idx_r == 6'h08 && !extProtect) begin
				shNxt[8] = ioWdata & 8'h7F;
			end
			if (idx_r == 6'h10 || idx_r == 6'h11) begin
				shNxt[idx_r[4:0]] = ioWdata;
			end
		end
		expRd = 8'h00;
		if (!ioSelData) begin
			expRd = {2'h0, idx_r};
		end else if (idx_r < 6'h09) begin
			expRd = sh_r[idx_r[4:0]];
		end else if (idx_r == 6'h10) begin
			expRd = sh_r[3][7] ? sh_r[16] : lightPenAddr[15:8];
		end else if (idx_r == 6'h11) begin
			expRd = sh_r[3][7] ? sh_r[17] : lightPenAddr[7:0];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			idx_r <= 6'h00;
			sh_r <= '0;
		end else begin
			idx_r <= idxNxt;
			sh_r <= shNxt;
		end
	end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	a_count_step: assert property (
		$changed(charCount_r) |-> charCount_r == $past(charCount_r) + 8'h01 || charCount_r == 8'h00)
		else $error("character counter jumped");
	a_char_period: assert property (
		$changed(charCount_r) |=> $stable(charCount_r)[*7])
		else $error("character clock period wrong");
	a_blank_start: assert property (
		$changed(charCount_r) && charCount_r == $past(sh_r[2]) |=> hBlank_r)
		else $error("blank did not start");
	a_blank_end: assert property (
		$changed(charCount_r) && charCount_r[5:0] == {$past(sh_r[5][7]), $past(sh_r[3][4:0])}
		&& charCount_r != $past(sh_r[2]) |=> !hBlank_r)
		else $error("blank did not end");
	a_sync_start: assert property (
		$changed(charCount_r) && charCount_r == $past(sh_r[4]) && sh_r[5][6:5] == 2'h0
		|=> hSync_r)
		else $error("undelayed retrace did not start");
	a_read_data: assert property (
		ioRd |=> ioRdata_r == $past(expRd))
		else $error("read data wrong");
	a_vtotal_map: assert property (
		!$past(ioWr) && !$past(ioWr, 2) |-> vTotal_r == {sh_r[7][5], sh_r[7][0], sh_r[6]})
		else $error("vertical total wrong");
	a_overflow_map: assert property (
		!$past(ioWr) && !$past(ioWr, 2) |-> {vRetraceStartHi_r, vDispEndHi_r, vBlankStart8_r,
		lineCompare8_r} == {sh_r[7][7], sh_r[7][2], sh_r[7][6], sh_r[7][1], sh_r[7][3],
		sh_r[7][4]})
		else $error("overflow bits wrong");
	a_pan_pixels: assert property (
		!$past(ioWr) && !$past(ioWr, 2) |-> bytePan_r == sh_r[8][6:5]
		&& panPixels_r == {sh_r[8][6:5], 3'h0})
		else $error("byte pan wrong");
	a_row_load: assert property (
		vRetraceDone |=> rowScan_r == sh_r[8][4:0])
		else $error("row scan not preset");
endmodule : crt_raster_timing_regs_asserts

bind crt_raster_timing_regs crt_raster_timing_regs_asserts chk (.*);

// ### verif/crt_display_monitor.sv
`timescale 1ns/10ps
// Display stand-in: widths of the last sync and blank pulses, in mclk
module crt_display_monitor (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        hSync_r,
	input  wire logic        hBlank_r,
	output logic      [15:0] syncWidth_r,
	output logic      [15:0] blankWidth_r
);
	logic [15:0] sRun_r, bRun_r, sRunNxt, bRunNxt, syncWidthNxt, blankWidthNxt;

	always_comb begin
		sRunNxt = hSync_r ? sRun_r + 16'h0001 : 16'h0000;
		bRunNxt = hBlank_r ? bRun_r + 16'h0001 : 16'h0000;
		syncWidthNxt = (!hSync_r && sRun_r != 16'h0000) ? sRun_r : syncWidth_r;
		blankWidthNxt = (!hBlank_r && bRun_r != 16'h0000) ? bRun_r : blankWidth_r;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sRun_r <= 16'h0000;
			bRun_r <= 16'h0000;
			syncWidth_r <= 16'h0000;
			blankWidth_r <= 16'h0000;
		end else begin
			sRun_r <= sRunNxt;
			bRun_r <= bRunNxt;
			syncWidth_r <= syncWidthNxt;
			blankWidth_r <= blankWidthNxt;
		end
	end
endmodule : crt_display_monitor

// ### verif/crt_raster_timing_regs_tb_top.sv
`timescale 1ns/10ps
module crt_raster_timing_regs_tb_top;
	import crt_timing_pkg::*;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        ioWr = 1'b0;
	logic        ioRd = 1'b0;
	logic        ioSelData = 1'b0;
	logic [7:0]  ioWdata = 8'h00;
	logic        extProtect = 1'b0;
	logic [15:0] lightPenAddr = 16'h0000;
	logic        vRetraceDone = 1'b0;
	logic [7:0]  ioRdata_r, charCount_r, q, d, s, e;
	logic        hDispEn_r, hBlank_r, hSync_r, lineEnd_r, vBlankStart8_r, lineCompare8_r;
	logic [9:0]  vTotal_r;
	logic [1:0]  vRetraceStartHi_r, vDispEndHi_r, bytePan_r;
	logic [4:0]  rowScan_r, panPixels_r;
	logic [15:0] syncWidth_r, blankWidth_r;
	logic [7:0]  regv [0:8];
	int          error_cnt = 0;
	int          check_count = 0;
	int          n, m, w;

	always #4 mclk = ~mclk;

	crt_raster_timing_regs DUT (.*);
	crt_display_monitor mon (.*);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic give_verdict();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : give_verdict

	// Index cycle, then one data cycle; read data is taken after that edge
	task automatic acc(input logic [5:0] i, input bit wr, input logic [7:0] wd);
		@(posedge mclk);
		ioWr <= 1'b1;
		ioSelData <= 1'b0;
		ioWdata <= {2'h0, i};
		@(posedge mclk);
		ioWr <= wr;
		ioRd <= !wr;
		ioSelData <= 1'b1;
		ioWdata <= wd;
		@(posedge mclk);
		ioWr <= 1'b0;
		ioRd <= 1'b0;
		#1 q = ioRdata_r;
	endtask : acc

	task automatic waitCnt(input logic [7:0] v);
		logic [7:0] prev;
		prev = charCount_r;
		for (n = 0; n < 9000; n++) begin
			@(posedge mclk);
			#1;
			if (charCount_r === v && prev !== v) break;
			prev = charCount_r;
		end
		if (n == 9000) begin
			error_cnt++;
			give_verdict();
		end
	endtask : waitCnt

	task automatic rise(input bit selSync);
		for (m = 1; m < 40; m++) begin
			@(posedge mclk);
			#1;
			if (selSync ? hSync_r === 1'b1 : hDispEn_r === 1'b1) break;
		end
		if (m == 40) begin
			error_cnt++;
			give_verdict();
		end
	endtask : rise

	// Pulse length over a 65-character line, wrap included
	function automatic logic [15:0] spanMclk(input logic [7:0] a, input logic [7:0] b);
		return 16'(((int'(b) + 65 - int'(a)) % 65) * 8);
	endfunction : spanMclk

	initial begin
		void'($urandom(32'hDE60));
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		#1 chk({charCount_r, rowScan_r, hBlank_r, hSync_r, hDispEn_r}, 16'h0000);
		for (int i = 0; i < 9; i++) begin
			acc(6'(i), 1'b0, 8'h00);
			chk(16'(q), 16'h0000);
			d = 8'($urandom);
			regv[i] = (i == 8) ? (d & 8'h7F) : d;
			acc(6'(i), 1'b1, d);
			acc(6'(i), 1'b0, 8'h00);
			chk(16'(q), 16'(regv[i]));
		end
		acc(6'h2A, 1'b1, d);
		acc(6'h2A, 1'b0, 8'h00);
		chk(16'(q), 16'h0000);
		@(posedge mclk);
		extProtect <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			acc(6'(i), 1'b1, ~regv[i]);
			acc(6'(i), 1'b0, 8'h00);
			chk(16'(q), 16'(regv[i]));
		end
		@(posedge mclk);
		extProtect <= 1'b0;
		acc(6'h11, 1'b1, 8'h80);
		d = 8'($urandom);
		for (int i = 2; i < 9; i++) begin
			acc(6'(i), 1'b1, d);
			acc(6'(i), 1'b0, 8'h00);
			if (i == 7) regv[7][4] = d[4];
			if (i == 8) regv[8] = d & 8'h7F;
			chk(16'(q), 16'(regv[i]));
		end
		acc(6'h11, 1'b1, 8'h3C);
		acc(6'h10, 1'b1, 8'h5A);
		@(posedge mclk);
		lightPenAddr <= 16'($urandom);
		for (int c = 0; c < 2; c++) begin
			acc(6'h03, 1'b1, {c[0], 7'h00});
			acc(6'h10, 1'b0, 8'h00);
			chk(16'(q), 16'(c ? 8'h5A : lightPenAddr[15:8]));
			acc(6'h11, 1'b0, 8'h00);
			chk(16'(q), 16'(c ? 8'h3C : lightPenAddr[7:0]));
		end
		d = 8'($urandom);
		e = 8'($urandom);
		acc(6'h06, 1'b1, d);
		acc(6'h07, 1'b1, e);
		repeat (3) @(posedge mclk);
		#1 chk(16'(vTotal_r), {6'h00, e[5], e[0], d});
		chk(16'({vRetraceStartHi_r, vDispEndHi_r, vBlankStart8_r, lineCompare8_r}),
			16'({e[7], e[2], e[6], e[1], e[3], e[4]}));
		acc(6'h00, 1'b1, 8'h3C);
		acc(6'h01, 1'b1, 8'h1E);
		for (int k = 0; k < 4; k++) begin
			s = 8'(10 + $urandom % 30);
			w = 1 + $urandom % 8;
			acc(6'h05, 1'b1, {1'b0, 2'(k), 5'(int'(s) + w)});
			acc(6'h04, 1'b1, s);
			acc(6'h03, 1'b1, {1'b0, 2'(k), 5'h00});
			// First zero may be a plain 8-bit rollover; a full line flushes stale pulses
			waitCnt(8'h00);
			waitCnt(8'h00);
			chk(16'(lineEnd_r), 16'h0001);
			rise(1'b0);
			chk(16'(m), 16'(1 + 8 * k));
			waitCnt(s);
			rise(1'b1);
			chk(16'(m), 16'(1 + 8 * k));
			repeat (8 * w + 4) @(posedge mclk);
			#1 chk(syncWidth_r, spanMclk(s, 8'(int'(s) + w)));
		end
		for (int b = 0; b < 2; b++) begin
			s = b ? 8'h14 : 8'h3D;
			e = b ? 8'h28 : 8'h02;
			acc(6'h05, 1'b1, {e[5], 7'h00});
			acc(6'h03, 1'b1, {3'h0, e[4:0]});
			acc(6'h02, 1'b1, s);
			waitCnt(s);
			waitCnt(s);
			repeat (200) @(posedge mclk);
			#1 chk(blankWidth_r, spanMclk(s, e));
		end
		for (int p = 0; p < 4; p++) begin
			d = {1'b0, 2'(p), 5'($urandom)};
			acc(6'h08, 1'b1, d);
			waitCnt(8'h01);
			@(posedge mclk);
			vRetraceDone <= 1'b1;
			@(posedge mclk);
			vRetraceDone <= 1'b0;
			#1 chk(16'(rowScan_r), 16'(d[4:0]));
			chk(16'({bytePan_r, panPixels_r}), 16'({2'(p), 2'(p), 3'h0}));
		end
		give_verdict();
	end
endmodule : crt_raster_timing_regs_tb_top
